// *** pkg/uirb_consts.vh ***
// Constants for the USB indirect register bridge.
// Assumes it is included by bare name from the bridge design files.
`ifndef UIRB_CONSTS_VH
`define UIRB_CONSTS_VH

// SFR locations of the two bridge registers
`define UIRB_SFR_ADDR_CTRL 8'h96
`define UIRB_SFR_DATA 8'h97

// Field layout of the address/control register
`define UIRB_BUSY_BIT 7
`define UIRB_AUTO_BIT 6
`define UIRB_TADDR_MSB 5
`define UIRB_TADDR_LSB 0

// Reset values
`define UIRB_CTRL_RESET 8'h00
`define UIRB_DATA_RESET 8'h00
`define UIRB_TADDR_RESET 6'h00
`define UIRB_EPSEL_RESET 4'h0
`define UIRB_RDATA_IDLE 8'h00

// Endpoint select field of the index register
`define UIRB_EPSEL_MSB 3
`define UIRB_EPSEL_LSB 0

// Controller register map, 6-bit target addresses
`define UIRB_UA_FUNC_ADDR 6'h00
`define UIRB_UA_POWER 6'h01
`define UIRB_UA_IN_IRQ_FLAGS 6'h02
`define UIRB_UA_OUT_IRQ_FLAGS 6'h04
`define UIRB_UA_COMMON_IRQ_FLAGS 6'h06
`define UIRB_UA_IN_IRQ_ENABLES 6'h07
`define UIRB_UA_OUT_IRQ_ENABLES 6'h09
`define UIRB_UA_COMMON_IRQ_ENABLES 6'h0B
`define UIRB_UA_FRAME_LOW 6'h0C
`define UIRB_UA_FRAME_HIGH 6'h0D
`define UIRB_UA_EP_INDEX 6'h0E
`define UIRB_UA_CLOCK_RECOVERY 6'h0F
`define UIRB_UA_EP_IN_CS_LOW 6'h11
`define UIRB_UA_EP_IN_CS_HIGH 6'h12
`define UIRB_UA_EP_OUT_CS_LOW 6'h14
`define UIRB_UA_EP_OUT_CS_HIGH 6'h15
`define UIRB_UA_EP_ZERO_RX_COUNT 6'h16
`define UIRB_UA_EP_OUT_COUNT_HIGH 6'h17
`define UIRB_UA_EP_ENABLE 6'h1E
`define UIRB_UA_FIFO_FIRST 6'h20
`define UIRB_UA_FIFO_LAST 6'h23

`endif

// *** rtl/uirb_addr_decode.v ***
// Target address decoder for the USB indirect register bridge.
// Assumes a 6-bit target address, pure combinational use.
`timescale 1ns/100ps
`default_nettype none
`include "uirb_consts.vh"

module uirb_addr_decode (
    input wire [5:0] taddr_in,
    output wire hit_out,
    output wire indexed_out,
    output wire index_sel_out
);

    // ==========================================================
    // Decode functions
    // ==========================================================
    function is_indexed;
        input [5:0] a;
        begin
            case (a)
                `UIRB_UA_EP_IN_CS_LOW, `UIRB_UA_EP_IN_CS_HIGH: is_indexed = 1'b1;
                `UIRB_UA_EP_OUT_CS_LOW, `UIRB_UA_EP_OUT_CS_HIGH: is_indexed = 1'b1;
                `UIRB_UA_EP_ZERO_RX_COUNT, `UIRB_UA_EP_OUT_COUNT_HIGH: is_indexed = 1'b1;
                default: is_indexed = 1'b0;
            endcase
        end
    endfunction

    function is_common;
        input [5:0] a;
        begin
            case (a)
                `UIRB_UA_IN_IRQ_FLAGS, `UIRB_UA_OUT_IRQ_FLAGS: is_common = 1'b1;
                `UIRB_UA_COMMON_IRQ_FLAGS: is_common = 1'b1;
                `UIRB_UA_IN_IRQ_ENABLES, `UIRB_UA_OUT_IRQ_ENABLES: is_common = 1'b1;
                `UIRB_UA_COMMON_IRQ_ENABLES: is_common = 1'b1;
                `UIRB_UA_FRAME_LOW, `UIRB_UA_FRAME_HIGH: is_common = 1'b1;
                `UIRB_UA_EP_INDEX: is_common = 1'b1;
                `UIRB_UA_CLOCK_RECOVERY: is_common = 1'b1;
                `UIRB_UA_FUNC_ADDR, `UIRB_UA_POWER, `UIRB_UA_EP_ENABLE: is_common = 1'b1;
                default: is_common = (a >= `UIRB_UA_FIFO_FIRST) && (a <= `UIRB_UA_FIFO_LAST);
            endcase
        end
    endfunction

    // ==========================================================
    // Outputs
    // ==========================================================
    assign indexed_out = is_indexed(taddr_in);
    assign hit_out = is_common(taddr_in) | is_indexed(taddr_in);
    assign index_sel_out = (taddr_in == `UIRB_UA_EP_INDEX);

endmodule
`default_nettype wire

// *** rtl/uirb_bridge.v ***
// Indirect access bridge from the SFR bus into the USB controller registers.
// Assumes single-cycle SFR strobes and a controller port that acknowledges
// each held request with a one-cycle ack; USB clock kept running by software.
//
// Overview of operation
// - Busy reads 1 while access pending
// - Writing busy 1 starts fetch, clears after
// - One write loads address and starts read
// - Auto-read: data read relaunches same-address fetch
// - Six-bit field selects target controller register
// - Address field kept after indirect write
// - Interrupt flags at 0x02, 0x04, 0x06
// - Interrupt enables at 0x07, 0x09, 0x0B
// - Frame number bytes at 0x0C, 0x0D
// - Endpoint selection register at 0x0E
// - Clock recovery control at 0x0F
// - Indexed IN control/status at 0x11, 0x12
// - Indexed OUT control/status at 0x14, 0x15
// - Endpoint0 count 0x16, OUT count high 0x17
// - Indexed accesses use last selected endpoint
`timescale 1ns/100ps
`default_nettype none
`include "uirb_consts.vh"

module uirb_bridge (
    input wire clk_in,
    input wire rst_n_in,
    // SFR bus side
    input wire [7:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_wdata_in,
    output wire sfr_hit_out,
    output wire [7:0] sfr_rdata_out,
    // Controller register file side
    output wire ureg_req_out,
    output wire ureg_we_out,
    output wire [5:0] ureg_addr_out,
    output wire [7:0] ureg_wdata_out,
    output wire ureg_indexed_out,
    output wire [3:0] ureg_ep_index_out,
    input wire [7:0] ureg_rdata_in,
    input wire ureg_ack_in
);

    // ==========================================================
    // States
    // ==========================================================
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_WRITE = 3'h4;

    // ==========================================================
    // Registers
    // ==========================================================
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg auto_q;
    reg auto_d;
    reg [5:0] taddr_q;
    reg [5:0] taddr_d;
    reg [7:0] data_q;
    reg [7:0] data_d;
    reg [3:0] ep_index_q;
    reg [3:0] ep_index_d;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg indexed_q;
    reg indexed_d;

    // ==========================================================
    // SFR strobe decode
    // ==========================================================
    wire sel_ctrl;
    wire sel_data;
    wire wr_ctrl;
    wire wr_data;
    wire rd_data;
    wire idle;
    wire busy;
    wire [7:0] ctrl_view;
    wire [5:0] next_taddr;
    wire start_rd;
    wire start_wr;
    wire next_hit;
    wire next_indexed;
    wire next_is_index;

    assign sel_ctrl = (sfr_addr_in == `UIRB_SFR_ADDR_CTRL);
    assign sel_data = (sfr_addr_in == `UIRB_SFR_DATA);
    assign sfr_hit_out = sel_ctrl | sel_data;
    assign wr_ctrl = sfr_wr_in & sel_ctrl;
    assign wr_data = sfr_wr_in & sel_data;
    assign rd_data = sfr_rd_in & sel_data;

    assign idle = state_q[0];
    // Busy covers both directions so software sees one flag
    assign busy = ~idle;

    assign ctrl_view = {busy, auto_q, taddr_q};

    // Combined address-and-busy write fetches the new address
    assign next_taddr = wr_ctrl ?
        sfr_wdata_in[`UIRB_TADDR_MSB:`UIRB_TADDR_LSB] : taddr_q;

    // Requests arriving while busy are dropped, not queued
    assign start_rd = idle & ((wr_ctrl & sfr_wdata_in[`UIRB_BUSY_BIT])
        | (rd_data & auto_q));
    assign start_wr = idle & wr_data;

    // ==========================================================
    // Target decode
    // ==========================================================
    uirb_addr_decode u_decode (
        .taddr_in(next_taddr),
        .hit_out(next_hit),
        .indexed_out(next_indexed),
        .index_sel_out(next_is_index)
    );

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always @* begin
        state_d = state_q;
        auto_d = auto_q;
        taddr_d = taddr_q;
        data_d = data_q;
        ep_index_d = ep_index_q;
        indexed_d = indexed_q;
        case (state_q)
            ST_IDLE: begin
                // Control writes only take effect while idle
                if (wr_ctrl) begin
                    auto_d = sfr_wdata_in[`UIRB_AUTO_BIT];
                    taddr_d = next_taddr;
                end
                indexed_d = next_indexed;
                if (start_rd) begin
                    if (next_hit) begin
                        state_d = ST_READ;
                    end else begin
                        // Unmapped targets read back as zero at once
                        data_d = `UIRB_RDATA_IDLE;
                    end
                end else if (start_wr) begin
                    data_d = sfr_wdata_in;
                    if (next_hit) begin
                        state_d = ST_WRITE;
                    end
                    if (next_hit & next_is_index) begin
                        ep_index_d = sfr_wdata_in[`UIRB_EPSEL_MSB:`UIRB_EPSEL_LSB];
                    end
                end
            end
            ST_READ: begin
                if (ureg_ack_in) begin
                    data_d = ureg_rdata_in;
                    state_d = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // Target address left alone for repeated writes
                if (ureg_ack_in) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // SFR read data
    // ==========================================================
    always @* begin
        rdata_d = rdata_q;
        if (sfr_rd_in) begin
            if (sel_ctrl) begin
                rdata_d = ctrl_view;
            end else if (sel_data) begin
                // Invalid while busy; software must poll first
                rdata_d = data_q;
            end else begin
                rdata_d = `UIRB_RDATA_IDLE;
            end
        end
    end

    // ==========================================================
    // Reset values
    // ==========================================================
    // Auto-read field reset carved out of the whole-register reset value
    localparam [7:0] CTRL_RESET = `UIRB_CTRL_RESET;
    localparam [0:0] AUTO_RESET = CTRL_RESET[`UIRB_AUTO_BIT];
    localparam [0:0] INDEXED_RESET = 1'b0;

    // ==========================================================
    // Sequencer state
    // ==========================================================
    // One-hot, so busy is a single inverted bit
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Auto-read flag
    // ==========================================================
    // Only a control write while idle may change it
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            auto_q <= AUTO_RESET;
        end else begin
            auto_q <= auto_d;
        end
    end

    // ==========================================================
    // Target address field
    // ==========================================================
    // Kept across data accesses for repeated transfers
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            taddr_q <= `UIRB_TADDR_RESET;
        end else begin
            taddr_q <= taddr_d;
        end
    end

    // ==========================================================
    // Data register
    // ==========================================================
    // Shared by fetched bytes and bytes awaiting write-out
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_q <= `UIRB_DATA_RESET;
        end else begin
            data_q <= data_d;
        end
    end

    // ==========================================================
    // Endpoint select copy
    // ==========================================================
    // Local copy so indexed targets need no extra fetch
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ep_index_q <= `UIRB_EPSEL_RESET;
        end else begin
            ep_index_q <= ep_index_d;
        end
    end

    // ==========================================================
    // Indexed target flag
    // ==========================================================
    // Registered so the controller port sees no decode path
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            indexed_q <= INDEXED_RESET;
        end else begin
            indexed_q <= indexed_d;
        end
    end

    // ==========================================================
    // Read data register
    // ==========================================================
    // Holds the last served byte until the next read strobe
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_q <= `UIRB_RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Controller port
    // ==========================================================
    // Request held as a level until the controller acknowledges
    assign ureg_req_out = ~idle;
    assign ureg_we_out = state_q[2];
    assign ureg_addr_out = taddr_q;
    assign ureg_wdata_out = data_q;
    assign ureg_indexed_out = indexed_q;
    // Index follows a write to the selection register at once
    assign ureg_ep_index_out = ep_index_q;
    assign sfr_rdata_out = rdata_q;

endmodule
`default_nettype wire

// *** rtl/uirb_bridge_pad.v ***
// Reserved.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** bench/uirb_ureg_model.sv ***
// Behavioural controller register file behind the bridge.
// Assumes one held request at a time, closed by a one-cycle ack.
`timescale 1ns/100ps
`default_nettype none
module uirb_ureg_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic indexed_in,
    input wire logic [3:0] ep_index_in,
    input wire logic [2:0] delay_in,
    output var logic [7:0] rdata_out,
    output var logic ack_out
);
    logic [7:0] mem_q [0:1023];
    logic [2:0] wait_q;
    wire [9:0] slot = indexed_in ? {ep_index_in, addr_in} : {4'h0, addr_in};
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            wait_q <= 3'h0;
            rdata_out <= 8'h00;
        end else if (req_in && !ack_out && wait_q == delay_in) begin
            ack_out <= 1'b1;
            wait_q <= 3'h0;
            rdata_out <= mem_q[slot];
            if (we_in)
                mem_q[slot] <= wdata_in;
        end else begin
            ack_out <= 1'b0;
            // Data only valid with ack; toggling keeps stale bytes from matching
            rdata_out <= ~rdata_out;
            wait_q <= (req_in && !ack_out) ? wait_q + 3'h1 : 3'h0;
        end
    end
endmodule
`default_nettype wire

// *** bench/uirb_bridge_monitor.sv ***
// Port checker for the indirect register bridge.
// Assumes it is bound to uirb_bridge and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module uirb_bridge_monitor (
    input wire clk_in,
    input wire rst_n_in,
    input wire [7:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_wdata_in,
    input wire sfr_hit_out,
    input wire [7:0] sfr_rdata_out,
    input wire ureg_req_out,
    input wire ureg_we_out,
    input wire [5:0] ureg_addr_out,
    input wire [7:0] ureg_wdata_out,
    input wire ureg_indexed_out,
    input wire [3:0] ureg_ep_index_out,
    input wire [7:0] ureg_rdata_in,
    input wire ureg_ack_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Requests taken only while idle; busy ones are dropped
    wire wr_c = sfr_wr_in && sfr_addr_in == 8'h96 && !ureg_req_out;
    wire wr_d = sfr_wr_in && sfr_addr_in == 8'h97 && !ureg_req_out;
    wire rd_c = sfr_rd_in && sfr_addr_in == 8'h96;
    wire rd_d = sfr_rd_in && sfr_addr_in == 8'h97;
    property p_hold;
        ureg_req_out && !ureg_ack_in |=> ureg_req_out && $stable(ureg_addr_out)
            && $stable(ureg_we_out) && $stable(ureg_wdata_out);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before ack");
    property p_drop;
        ureg_req_out && ureg_ack_in |=> !ureg_req_out;
    endproperty
    a_drop: assert property (p_drop) else $error("busy kept after ack");
    property p_ctrl;
        wr_c |=> ureg_addr_out == $past(sfr_wdata_in[5:0]) && !ureg_we_out;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("address field not loaded");
    property p_data;
        wr_d |=> ureg_wdata_out == $past(sfr_wdata_in) && $stable(ureg_addr_out);
    endproperty
    a_data: assert property (p_data) else $error("data write mishandled");
    property p_busy;
        rd_c && ureg_req_out && !ureg_ack_in |=> sfr_rdata_out[7];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not shown");
    property p_idle;
        rd_c && !ureg_req_out |=> !sfr_rdata_out[7] && sfr_rdata_out[5:0] == ureg_addr_out;
    endproperty
    a_idle: assert property (p_idle) else $error("idle control read wrong");
    property p_fetch;
        ureg_req_out && ureg_ack_in && !ureg_we_out |=>
            ureg_wdata_out == $past(ureg_rdata_in);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetched byte lost");
    property p_dread;
        rd_d |=> sfr_rdata_out == $past(ureg_wdata_out);
    endproperty
    a_dread: assert property (p_dread) else $error("data register read wrong");
    property p_epsel;
        wr_d && ureg_addr_out == 6'h0E |=> ureg_ep_index_out == $past(sfr_wdata_in[3:0]);
    endproperty
    a_epsel: assert property (p_epsel) else $error("endpoint not selected");
    property p_index;
        ureg_req_out |-> ureg_indexed_out == (ureg_addr_out >= 6'h11
            && ureg_addr_out <= 6'h17 && ureg_addr_out != 6'h13);
    endproperty
    a_index: assert property (p_index) else $error("indexed decode wrong");
    property p_hit;
        sfr_hit_out == (sfr_addr_in == 8'h96 || sfr_addr_in == 8'h97);
    endproperty
    a_hit: assert property (p_hit) else $error("hit decode wrong");
    c_read: cover property (ureg_req_out && !ureg_we_out && ureg_ack_in);
    c_write: cover property (ureg_req_out && ureg_we_out && ureg_ack_in);
    c_drop: cover property (sfr_wr_in && ureg_req_out);
endmodule
bind uirb_bridge uirb_bridge_monitor i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_hit_out(sfr_hit_out), .sfr_rdata_out(sfr_rdata_out),
    .ureg_req_out(ureg_req_out), .ureg_we_out(ureg_we_out), .ureg_addr_out(ureg_addr_out),
    .ureg_wdata_out(ureg_wdata_out), .ureg_indexed_out(ureg_indexed_out),
    .ureg_ep_index_out(ureg_ep_index_out), .ureg_rdata_in(ureg_rdata_in),
    .ureg_ack_in(ureg_ack_in));
`default_nettype wire

// *** bench/test_usb_indirect_register_bridge.sv ***
// Self-checking bench for the indirect register bridge.
// Assumes the controller model and bound checker beside it.
`timescale 1ns/100ps
`default_nettype none
module test_usb_indirect_register_bridge;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic sfr_rd_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [2:0] delay = 3'h2;
    wire sfr_hit_out, ureg_req_out, ureg_we_out, ureg_indexed_out, ureg_ack_in;
    wire [7:0] sfr_rdata_out, ureg_wdata_out, ureg_rdata_in;
    wire [5:0] ureg_addr_out;
    wire [3:0] ureg_ep_index_out;
    int fails = 0;
    int samples_checked = 0;
    logic [7:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic polling = 1'b0;
    logic [31:0] seed = 32'h00004A6B;
    localparam logic [5:0] MAP_ADDRS [16] = '{6'h02, 6'h04, 6'h06, 6'h07, 6'h09, 6'h0B,
        6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h11, 6'h12, 6'h14, 6'h15, 6'h16, 6'h17};
    uirb_bridge i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_hit_out(sfr_hit_out), .sfr_rdata_out(sfr_rdata_out), .ureg_req_out(ureg_req_out),
        .ureg_we_out(ureg_we_out), .ureg_addr_out(ureg_addr_out),
        .ureg_wdata_out(ureg_wdata_out), .ureg_indexed_out(ureg_indexed_out),
        .ureg_ep_index_out(ureg_ep_index_out), .ureg_rdata_in(ureg_rdata_in),
        .ureg_ack_in(ureg_ack_in));
    uirb_ureg_model i_ctl (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(ureg_req_out),
        .we_in(ureg_we_out), .addr_in(ureg_addr_out), .wdata_in(ureg_wdata_out),
        .indexed_in(ureg_indexed_out), .ep_index_in(ureg_ep_index_out), .delay_in(delay),
        .rdata_out(ureg_rdata_in), .ack_out(ureg_ack_in));
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Listed targets start a fetch; the unlisted ones probed here complete at once
    function automatic logic [7:0] mapped(input logic [5:0] a);
        mapped = 8'h00;
        foreach (MAP_ADDRS[k])
            if (MAP_ADDRS[k] == a)
                mapped = 8'h01;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] expv);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        exp_q.push_back(expv);
        @(negedge clk_in);
        sfr_rd_in = 1'b0;
    endtask
    // Returns busy reads seen; bounded so a stuck flag cannot hang
    task automatic poll(output int n);
        n = -1;
        polling = 1'b1;
        do begin
            @(negedge clk_in);
            sfr_addr_in = 8'h96;
            sfr_rd_in = 1'b1;
            @(negedge clk_in);
            sfr_rd_in = 1'b0;
            n++;
        end while (sfr_rdata_out[7] !== 1'b0 && n < 40);
        polling = 1'b0;
    endtask
    task automatic iwr(input logic [5:0] a, input logic [7:0] d);
        int n;
        sfr_wr(8'h96, {2'b00, a});
        sfr_wr(8'h97, d);
        poll(n);
    endtask
    task automatic ird(input logic [5:0] a, input logic [7:0] d);
        int n;
        sfr_wr(8'h96, {2'b10, a});
        poll(n);
        check(8'(n > 0 && n < 40), 8'h01);
        sfr_rd(8'h97, d);
    endtask
    always @(posedge clk_in) begin
        if (rd_pend)
            check(sfr_rdata_out, exp_q.pop_front());
        rd_pend <= sfr_rd_in && sfr_hit_out && !polling;
    end
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #2000000;
        fails++;
        final_report();
    end
    initial begin
        int n;
        logic [7:0] v;
        repeat (5) @(negedge clk_in);
        rst_n_in = 1'b1;
        check({2'b00, ureg_req_out, ureg_we_out, ureg_ep_index_out}, 8'h00);
        sfr_rd(8'h96, 8'h00);
        sfr_rd(8'h97, 8'h00);
        foreach (MAP_ADDRS[i]) begin
            delay = 3'(rnd() % 8'h06 + 8'h02);
            v = rnd();
            iwr(MAP_ADDRS[i], v);
            ird(MAP_ADDRS[i], v);
            sfr_rd(8'h96, {2'b00, MAP_ADDRS[i]});
        end
        foreach (MAP_ADDRS[i]) begin
            v = {2'b10, MAP_ADDRS[i] + 6'h01};
            sfr_wr(8'h96, v);
            poll(n);
            check(8'(n > 0), mapped(v[5:0]));
        end
        iwr(6'h0E, 8'h01);
        iwr(6'h11, 8'hA5);
        iwr(6'h0E, 8'h02);
        iwr(6'h11, 8'h3C);
        iwr(6'h0E, 8'h01);
        ird(6'h11, 8'hA5);
        v = rnd();
        iwr(6'h20, v);
        sfr_wr(8'h96, 8'hE0);
        poll(n);
        repeat (3) begin
            sfr_rd(8'h97, v);
            poll(n);
            check(8'(n > 0), 8'h01);
            sfr_rd(8'h96, 8'h60);
        end
        sfr_wr(8'h96, 8'h20);
        sfr_rd(8'h97, v);
        poll(n);
        check(8'(n), 8'h00);
        sfr_wr(8'h96, 8'h13);
        sfr_wr(8'h97, v);
        poll(n);
        check(8'(n), 8'h00);
        sfr_rd(8'h97, v);
        delay = 3'h7;
        v = rnd();
        sfr_wr(8'h96, 8'h0C);
        sfr_wr(8'h97, v);
        sfr_wr(8'h96, 8'h8F);
        poll(n);
        check(8'(n > 0), 8'h01);
        sfr_rd(8'h96, 8'h0C);
        ird(6'h0C, v);
        repeat (3) @(negedge clk_in);
        final_report();
    end
endmodule
`default_nettype wire
